// [logic/flash_cmd_device.sv]
// Purpose: flash-side decoder for global lock/unlock and software reset
// Assumes: serial clock runs only inside frames
// Notes: commands act once cs_n release has crossed over
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module flash_cmd_device
(
  spi_link_if.device               LINK,
  input  wire logic                REF_CLK,
  input  wire logic                RST,
  input  wire logic                PROTECT_SCHEME_SELECT,
  input  flash_cmd_pkg::lock_vec_t BP_PROTECT,
  input  wire logic                STATUS_VOL_WR,
  input  flash_cmd_pkg::byte_t     STATUS_VOL_DATA,
  input  wire logic                PARAM_WR,
  input  flash_cmd_pkg::byte_t     PARAM_DATA,
  input  wire logic                MODE_WR,
  input  flash_cmd_pkg::byte_t     MODE_DATA,
  input  wire logic                SUSPEND_SET,
  input  wire logic                SUSPEND_CLR,
  output flash_cmd_pkg::lock_vec_t LOCK_BITS,
  output flash_cmd_pkg::lock_vec_t PROTECTED,
  output logic                     WRITE_ENABLE_LATCH,
  output logic                     SUSPEND_FLAG,
  output flash_cmd_pkg::byte_t     STATUS_VOL,
  output flash_cmd_pkg::byte_t     READ_PARAM_BYTE,
  output flash_cmd_pkg::byte_t     BYPASS_MODE_BYTE,
  output logic                     BUSY,
  output logic                     ABORT,
  output logic                     RESET_ARMED
);
  import flash_cmd_pkg::*;

  logic [3:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  byte_t      opcode_reg;
  logic       byte_tog_reg;
  logic       long_tog_reg;
  wire  byte_t opcode_full = {shift_reg, LINK.serial_in};

  always_ff @(posedge LINK.sclk or posedge LINK.cs_n) begin
    if (LINK.cs_n) begin
      bit_cnt_reg <= BIT_CNT_ZERO;
      shift_reg   <= 7'h00;
    end else begin
      if (bit_cnt_reg != BIT_CNT_MAX) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      shift_reg <= opcode_full[6:0];
    end
  end

  // marks cross as toggles; opcode_reg holds until the next eighth bit
  always_ff @(posedge LINK.sclk or posedge RST) begin
    if (RST) begin
      opcode_reg   <= 8'h00;
      byte_tog_reg <= 1'b0;
      long_tog_reg <= 1'b0;
    end else if (!LINK.cs_n) begin
      if (bit_cnt_reg == OPCODE_BITS - 4'h1) begin
        opcode_reg   <= opcode_full;
        byte_tog_reg <= ~byte_tog_reg;
      end
      if (bit_cnt_reg == OPCODE_BITS) begin
        long_tog_reg <= ~long_tog_reg;
      end
    end
  end

  logic [2:0] sync_q;
  flash_sync2 #(
    .WIDTH     (3),
    .RESET_VAL (8'h04)
  ) u_sync (
    .clk (REF_CLK),
    .rst (RST),
    .d   ({LINK.cs_n, long_tog_reg, byte_tog_reg}),
    .q   (sync_q)
  );

  wire cs_n_s     = sync_q[2];
  wire long_tog_s = sync_q[1];
  wire byte_tog_s = sync_q[0];

  logic       cs_q_reg;
  logic       byte_seen_reg;
  logic       long_seen_reg;
  lock_vec_t  lock_reg,   lock_next;
  lock_vec_t  prot_reg;
  logic       wel_reg,    wel_next;
  logic       sus_reg,    sus_next;
  byte_t      svol_reg,   svol_next;
  byte_t      param_reg,  param_next;
  byte_t      mode_reg,   mode_next;
  logic       armed_reg,  armed_next;
  logic [11:0] rst_cnt_reg, rst_cnt_next;
  logic       busy_reg;
  logic       abort_reg;

  wire frame_end = cs_n_s & ~cs_q_reg;
  wire got_byte  = frame_end & (byte_tog_s != byte_seen_reg);
  wire is_long   = long_tog_s != long_seen_reg;
  wire in_reset  = rst_cnt_reg != CNT12_ZERO;
  wire cmd_any   = got_byte & ~in_reset;
  wire cmd_ok    = cmd_any & ~is_long;

  wire op_wren    = cmd_ok & (opcode_reg == OP_WRITE_ENABLE);
  wire op_wrdi    = cmd_ok & (opcode_reg == OP_WRITE_DISABLE);
  wire op_lock    = cmd_ok & (opcode_reg == OP_GLOBAL_LOCK)   & wel_reg;
  wire op_unlock  = cmd_ok & (opcode_reg == OP_GLOBAL_UNLOCK) & wel_reg;
  wire op_arm     = cmd_ok & (opcode_reg == OP_RESET_ENABLE);
  wire op_reset   = cmd_ok & (opcode_reg == OP_RESET) & armed_reg;

  always_comb begin
    lock_next  = lock_reg;
    wel_next   = wel_reg;
    sus_next   = sus_reg;
    svol_next  = svol_reg;
    param_next = param_reg;
    mode_next  = mode_reg;
    if (op_reset) begin
      lock_next  = LOCK_ALL_SET;
      wel_next   = 1'b0;
      sus_next   = 1'b0;
      svol_next  = STATUS_VOL_DEFAULT;
      param_next = READ_PARAM_DEFAULT;
      mode_next  = BYPASS_MODE_DEFAULT;
    end else if (!in_reset) begin
      if (op_lock) begin
        lock_next = LOCK_ALL_SET;
      end
      if (op_unlock) begin
        lock_next = LOCK_ALL_CLEAR;
      end
      if (op_wren) begin
        wel_next = 1'b1;
      end
      if (op_wrdi) begin
        wel_next = 1'b0;
      end
      if (SUSPEND_SET) begin
        sus_next = 1'b1;
      end else if (SUSPEND_CLR) begin
        sus_next = 1'b0;
      end
      if (STATUS_VOL_WR) begin
        svol_next = STATUS_VOL_DATA;
      end
      if (PARAM_WR) begin
        param_next = PARAM_DATA;
      end
      if (MODE_WR) begin
        mode_next = MODE_DATA;
      end
    end
  end

  // only the next complete command may use the arm
  always_comb begin
    armed_next = armed_reg;
    if (cmd_any) begin
      armed_next = op_arm;
    end
  end

  always_comb begin
    rst_cnt_next = rst_cnt_reg;
    if (op_reset) begin
      rst_cnt_next = RESET_CYCLES;
    end else if (in_reset) begin
      rst_cnt_next = rst_cnt_reg - CNT12_ONE;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cs_q_reg      <= 1'b1;
      byte_seen_reg <= 1'b0;
      long_seen_reg <= 1'b0;
    end else begin
      cs_q_reg <= cs_n_s;
      if (frame_end) begin
        byte_seen_reg <= byte_tog_s;
        long_seen_reg <= long_tog_s;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lock_reg  <= LOCK_ALL_SET;
      wel_reg   <= 1'b0;
      sus_reg   <= 1'b0;
      svol_reg  <= STATUS_VOL_DEFAULT;
      param_reg <= READ_PARAM_DEFAULT;
      mode_reg  <= BYPASS_MODE_DEFAULT;
    end else begin
      lock_reg  <= lock_next;
      wel_reg   <= wel_next;
      sus_reg   <= sus_next;
      svol_reg  <= svol_next;
      param_reg <= param_next;
      mode_reg  <= mode_next;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      armed_reg   <= 1'b0;
      rst_cnt_reg <= CNT12_ZERO;
      busy_reg    <= 1'b0;
      abort_reg   <= 1'b0;
      prot_reg    <= LOCK_ALL_SET;
    end else begin
      armed_reg   <= armed_next;
      rst_cnt_reg <= rst_cnt_next;
      busy_reg    <= rst_cnt_next != CNT12_ZERO;
      abort_reg   <= op_reset;
      prot_reg    <= PROTECT_SCHEME_SELECT ? lock_next : BP_PROTECT;
    end
  end

  // ABORT is one pulse; engines must drop their work on it
  assign LOCK_BITS          = lock_reg;
  assign PROTECTED          = prot_reg;
  assign WRITE_ENABLE_LATCH = wel_reg;
  assign SUSPEND_FLAG       = sus_reg;
  assign STATUS_VOL         = svol_reg;
  assign READ_PARAM_BYTE    = param_reg;
  assign BYPASS_MODE_BYTE   = mode_reg;
  assign BUSY               = busy_reg;
  assign ABORT              = abort_reg;
  assign RESET_ARMED        = armed_reg;

endmodule : flash_cmd_device

// [logic/flash_cmd_pkg.sv]
// Purpose: constants for the global lock and soft reset commands
// Assumes: reference clock of 125 MHz on both ends
package flash_cmd_pkg;

  localparam int LOCK_COUNT = 64;
  typedef logic [LOCK_COUNT-1:0] lock_vec_t;
  typedef logic [7:0]            byte_t;

  localparam byte_t OP_WRITE_ENABLE  = 8'h06;
  localparam byte_t OP_WRITE_DISABLE = 8'h04;
  localparam byte_t OP_GLOBAL_LOCK   = 8'h7E;
  localparam byte_t OP_GLOBAL_UNLOCK = 8'h98;
  localparam byte_t OP_RESET_ENABLE  = 8'h66;
  localparam byte_t OP_RESET         = 8'h99;

  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_MAX  = 4'hF;
  localparam logic [3:0] OPCODE_BITS  = 4'h8;
  localparam logic [2:0] BIT_IDX_MSB  = 3'h7;

  localparam lock_vec_t LOCK_ALL_SET   = {LOCK_COUNT{1'b1}};
  localparam lock_vec_t LOCK_ALL_CLEAR = {LOCK_COUNT{1'b0}};
  localparam byte_t STATUS_VOL_DEFAULT = 8'h00;
  localparam byte_t READ_PARAM_DEFAULT = 8'h00;
  localparam byte_t BYPASS_MODE_DEFAULT = 8'h00;

  localparam int REF_CLK_PERIOD_NS = 8;
  localparam int RESET_TIME_US     = 30;
  localparam int RESET_CYCLES_INT  = (RESET_TIME_US * 1000) / REF_CLK_PERIOD_NS;
  localparam logic [11:0] RESET_CYCLES = 12'(RESET_CYCLES_INT);
  localparam logic [11:0] CNT12_ZERO   = 12'h000;
  localparam logic [11:0] CNT12_ONE    = 12'h001;

  localparam int POWERUP_WRITE_DELAY_MS = 5;
  localparam int POWERUP_CYCLES_DEF =
    (POWERUP_WRITE_DELAY_MS * 1000000 + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam logic [19:0] CNT20_ZERO = 20'h00000;

  localparam int DESELECT_NS = 50;
  localparam logic [2:0] DESELECT_CYCLES =
    3'((DESELECT_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS);
  localparam logic [2:0] SCLK_HALF_CYCLES = 3'h2;
  localparam logic [2:0] TICK_ONE         = 3'h1;

  localparam logic [3:0] CMD_OFFSET    = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  localparam int ST_BUSY    = 0;
  localparam int ST_PWR_OK  = 1;
  localparam int ST_HOLDOFF = 2;
  localparam int ST_ARMED   = 3;
  localparam int ST_LAST_LO = 8;

  function automatic logic is_write_type(input byte_t op);
    return (op == OP_WRITE_ENABLE) || (op == OP_GLOBAL_LOCK) || (op == OP_GLOBAL_UNLOCK);
  endfunction : is_write_type

endpackage : flash_cmd_pkg

// [logic/spi_link_if.sv]
// Purpose: serial link between command host and flash device
// Assumes: one data line toward the device suffices
// Notes: host makes the serial clock; all wires one-way
`timescale 1ns/10ps
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic serial_in;
  modport host   (output sclk, output cs_n, output serial_in);
  modport device (input sclk, input cs_n, input serial_in);
endinterface : spi_link_if

// [logic/flash_sync2.sv]
// Purpose: two-flop synchroniser for level signals
// Assumes: levels or toggles held several clocks
// Notes: stage one feeds only stage two
`timescale 1ns/10ps
module flash_sync2 #(
  parameter int         WIDTH     = 1,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VAL[WIDTH-1:0];
      q        <= RESET_VAL[WIDTH-1:0];
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : flash_sync2

// [logic/flash_cmd_host.sv]
// Purpose: AXI4-Lite controlled host that sends single-byte flash commands
// Assumes: one opcode per command write
// Notes: serial clock divided from REF_CLK
`timescale 1ns/10ps
module flash_cmd_host
#(
  parameter int POWERUP_CYCLES = flash_cmd_pkg::POWERUP_CYCLES_DEF
) (
  spi_link_if.host               LINK,
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [3:0]        AWADDR,
  input  wire logic              WVALID,
  output logic                   WREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  output logic                   BVALID,
  input  wire logic              BREADY,
  output logic [1:0]             BRESP,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  input  wire logic [3:0]        ARADDR,
  output logic                   RVALID,
  input  wire logic              RREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP
);
  import flash_cmd_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW  = 3'b001,
    H_HIGH = 3'b010,
    H_END  = 3'b011,
    H_GAP  = 3'b100
  } hstate_e;

  hstate_e     state_reg;
  logic [2:0]  tick_reg;
  logic [2:0]  bit_idx_reg;
  byte_t       op_reg;
  byte_t       last_op_reg;
  logic        sclk_reg, cs_n_reg, sdo_reg;
  logic [19:0] pwr_cnt_reg;
  logic [11:0] hold_cnt_reg;
  logic        aw_full_reg, w_full_reg;
  logic [3:0]  awaddr_reg;
  byte_t       wbyte_reg;
  logic        wlane_reg;
  logic        bvalid_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  wire pwr_ok   = pwr_cnt_reg == 20'(POWERUP_CYCLES);
  wire holdoff  = hold_cnt_reg != CNT12_ZERO;
  wire idle     = state_reg == H_IDLE;
  wire tick_end = tick_reg == TICK_ONE;
  wire armed    = last_op_reg == OP_RESET_ENABLE;
  wire wr_exec  = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire is_cmd   = awaddr_reg == CMD_OFFSET;
  // busy link, reset holdoff, or write-type before power-up
  wire refuse   = ~idle | holdoff | (is_write_type(wbyte_reg) & ~pwr_ok);
  wire start    = wr_exec & is_cmd & wlane_reg & ~refuse;
  wire frame_done = (state_reg == H_END) & tick_end;
  wire reset_sent = frame_done & (op_reg == OP_RESET) & armed;
  wire [31:0] status_word = {16'h0000, last_op_reg, 4'h0,
                             armed, holdoff, pwr_ok, ~idle};

  // cs low, eight bits MSB first, cs high
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_reg   <= H_IDLE;
      tick_reg    <= TICK_ONE;
      bit_idx_reg <= BIT_IDX_MSB;
      op_reg      <= 8'h00;
      sclk_reg    <= 1'b0;
      cs_n_reg    <= 1'b1;
      sdo_reg     <= 1'b0;
    end else begin
      tick_reg <= tick_end ? SCLK_HALF_CYCLES : tick_reg - TICK_ONE;
      unique case (state_reg)
        H_IDLE: begin
          if (start) begin
            op_reg      <= wbyte_reg;
            cs_n_reg    <= 1'b0;
            sdo_reg     <= wbyte_reg[BIT_IDX_MSB];
            bit_idx_reg <= BIT_IDX_MSB;
            tick_reg    <= SCLK_HALF_CYCLES;
            state_reg   <= H_LOW;
          end
        end
        H_LOW: begin
          if (tick_end) begin
            sclk_reg  <= 1'b1;
            state_reg <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tick_end) begin
            sclk_reg <= 1'b0;
            if (bit_idx_reg == 3'h0) begin
              state_reg <= H_END;
            end else begin
              bit_idx_reg <= bit_idx_reg - 3'h1;
              sdo_reg     <= op_reg[bit_idx_reg - 3'h1];
              state_reg   <= H_LOW;
            end
          end
        end
        H_END: begin
          if (tick_end) begin
            cs_n_reg  <= 1'b1;
            tick_reg  <= DESELECT_CYCLES;
            state_reg <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick_end) begin
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
          cs_n_reg  <= 1'b1;
          sclk_reg  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pwr_cnt_reg  <= CNT20_ZERO;
      hold_cnt_reg <= CNT12_ZERO;
      last_op_reg  <= 8'h00;
    end else begin
      if (!pwr_ok) begin
        pwr_cnt_reg <= pwr_cnt_reg + 20'h00001;
      end
      if (reset_sent) begin
        hold_cnt_reg <= RESET_CYCLES;
      end else if (holdoff) begin
        hold_cnt_reg <= hold_cnt_reg - CNT12_ONE;
      end
      if (frame_done) begin
        last_op_reg <= op_reg;
      end
    end
  end

  // address and data taken in either order
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= 4'h0;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (AWVALID && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= AWADDR;
      end
      if (WVALID && !w_full_reg) begin
        w_full_reg <= 1'b1;
        wbyte_reg  <= WDATA[7:0];
        wlane_reg  <= WSTRB[0];
      end
      if (wr_exec) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (!is_cmd || (wlane_reg && refuse)) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_reg && BREADY) begin
        bvalid_reg  <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= RESP_OKAY;
    end else if (rvalid_reg) begin
      if (RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end else if (ARVALID) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= (ARADDR == STATUS_OFFSET) ? status_word : 32'h00000000;
      rresp_reg  <= (ARADDR == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  assign AWREADY       = ~aw_full_reg;
  assign WREADY        = ~w_full_reg;
  assign BVALID        = bvalid_reg;
  assign BRESP         = bresp_reg;
  assign ARREADY       = ~rvalid_reg;
  assign RVALID        = rvalid_reg;
  assign RDATA         = rdata_reg;
  assign RRESP         = rresp_reg;
  assign LINK.sclk      = sclk_reg;
  assign LINK.cs_n      = cs_n_reg;
  assign LINK.serial_in = sdo_reg;

endmodule : flash_cmd_host

// [sim/flash_cmd_chk.sv]
// Purpose: link framing and device state checks
// Assumes: serial clock high and low two REF_CLK each
// Notes: sees the link wires, the protection select and BP_PROTECT inputs, and the device outputs
`timescale 1ns/10ps
module flash_cmd_chk
  import flash_cmd_pkg::*;
(
  input  wire logic                REF_CLK,
  input  wire logic                RST,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                serial_in,
  input  wire logic                PROTECT_SCHEME_SELECT,
  input  flash_cmd_pkg::lock_vec_t BP_PROTECT,
  input  flash_cmd_pkg::lock_vec_t LOCK_BITS,
  input  flash_cmd_pkg::lock_vec_t PROTECTED,
  input  wire logic                WRITE_ENABLE_LATCH,
  input  wire logic                SUSPEND_FLAG,
  input  flash_cmd_pkg::byte_t     STATUS_VOL,
  input  flash_cmd_pkg::byte_t     READ_PARAM_BYTE,
  input  flash_cmd_pkg::byte_t     BYPASS_MODE_BYTE,
  input  wire logic                BUSY,
  input  wire logic                ABORT,
  input  wire logic                RESET_ARMED
);
  logic [3:0]                bit_cnt_reg;
  logic [11:0]               busy_cnt_reg;
  logic                      sclk_q_reg;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) sclk_q_reg <= 1'h0;
    else sclk_q_reg <= sclk;
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) bit_cnt_reg <= 4'h0;
    else if (cs_n) bit_cnt_reg <= 4'h0;
    else if (sclk && !sclk_q_reg) bit_cnt_reg <= bit_cnt_reg + 4'h1;
  end
  // busy span is too long for a repetition
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) busy_cnt_reg <= 12'h000;
    else if (BUSY) busy_cnt_reg <= busy_cnt_reg + 12'h001;
    else busy_cnt_reg <= 12'h000;
  end

  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock active outside a frame");
  a_eight_bits: assert property ($rose(cs_n) |-> bit_cnt_reg == OPCODE_BITS)
    else $error("frame not eight bits");
  a_bit_hold: assert property (sclk && $past(sclk) |-> $stable(serial_in))
    else $error("serial data moved while clock high");
  a_high_phase: assert property ($rose(sclk) |-> ##1 sclk ##1 !sclk)
    else $error("serial clock high phase wrong");
  a_lock_uniform: assert property (LOCK_BITS == LOCK_ALL_SET || LOCK_BITS == LOCK_ALL_CLEAR)
    else $error("lock bits not all equal");
  a_lock_needs_wel: assert property ($changed(LOCK_BITS) && !ABORT |-> $past(WRITE_ENABLE_LATCH))
    else $error("lock changed without latch");
  a_reset_state: assert property (ABORT |-> LOCK_BITS == LOCK_ALL_SET && BUSY && !RESET_ARMED)
    else $error("reset state wrong");
  a_reset_volatile: assert property (ABORT |-> !WRITE_ENABLE_LATCH && !SUSPEND_FLAG
    && STATUS_VOL == STATUS_VOL_DEFAULT && READ_PARAM_BYTE == READ_PARAM_DEFAULT
    && BYPASS_MODE_BYTE == BYPASS_MODE_DEFAULT)
    else $error("reset kept a volatile setting");
  a_busy_span: assert property ($fell(BUSY) |-> busy_cnt_reg == RESET_CYCLES)
    else $error("reset interval length wrong");
  a_busy_frozen: assert property (BUSY && $past(BUSY) |-> $stable(LOCK_BITS)
    && $stable(READ_PARAM_BYTE) && $stable(WRITE_ENABLE_LATCH))
    else $error("state moved while busy");
  a_protect_src: assert property (!$past(RST) |-> PROTECTED ==
    ($past(PROTECT_SCHEME_SELECT) ? LOCK_BITS : $past(BP_PROTECT)))
    else $error("protection source wrong");
endmodule : flash_cmd_chk

// [sim/global_lock_and_soft_reset_tb.sv]
// Purpose: host over AXI4-Lite, spare device end by hand
// Assumes: short power-up wait through POWERUP_CYCLES
// Notes: spare end gets frames the host never makes
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module global_lock_and_soft_reset_tb;
  import flash_cmd_pkg::*;
  localparam int PU = 50;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0]  bresp, rresp, rs_v;
  logic        pss, vol_wr, par_wr, mod_wr, s_set, s_clr;
  logic        write_enable_latch, susp, busy, abort, armed, armed2;
  lock_vec_t   bp, lock_bits, prot, lock2;
  byte_t       vol_d, par_d, mod_d, stat_vol, rparam, bmode, sh;
  int          fails, num_checks, nb;

  spi_link_if lnk();
  spi_link_if lnk2();

  flash_cmd_host #(.POWERUP_CYCLES(PU)) u_flash_cmd_host (
    .LINK(lnk.host), .REF_CLK(clk), .RST(rst), .AWVALID(awvalid), .AWREADY(awready),
    .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
    .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready),
    .RDATA(rdata), .RRESP(rresp));
  flash_cmd_device u_flash_cmd_device (
    .LINK(lnk.device), .REF_CLK(clk), .RST(rst), .PROTECT_SCHEME_SELECT(pss),
    .BP_PROTECT(bp), .STATUS_VOL_WR(vol_wr), .STATUS_VOL_DATA(vol_d), .PARAM_WR(par_wr),
    .PARAM_DATA(par_d), .MODE_WR(mod_wr), .MODE_DATA(mod_d), .SUSPEND_SET(s_set),
    .SUSPEND_CLR(s_clr), .LOCK_BITS(lock_bits), .PROTECTED(prot),
    .WRITE_ENABLE_LATCH(write_enable_latch), .SUSPEND_FLAG(susp), .STATUS_VOL(stat_vol),
    .READ_PARAM_BYTE(rparam), .BYPASS_MODE_BYTE(bmode), .BUSY(busy), .ABORT(abort),
    .RESET_ARMED(armed));
  flash_cmd_device u_flash_cmd_device2 (
    .LINK(lnk2.device), .REF_CLK(clk), .RST(rst), .PROTECT_SCHEME_SELECT(pss),
    .BP_PROTECT(bp), .STATUS_VOL_WR(vol_wr), .STATUS_VOL_DATA(vol_d), .PARAM_WR(par_wr),
    .PARAM_DATA(par_d), .MODE_WR(mod_wr), .MODE_DATA(mod_d), .SUSPEND_SET(s_set),
    .SUSPEND_CLR(s_clr), .LOCK_BITS(lock2), .PROTECTED(), .WRITE_ENABLE_LATCH(),
    .SUSPEND_FLAG(), .STATUS_VOL(), .READ_PARAM_BYTE(), .BYPASS_MODE_BYTE(), .BUSY(),
    .ABORT(), .RESET_ARMED(armed2));
  flash_cmd_chk u_flash_cmd_chk (
    .REF_CLK(clk), .RST(rst), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .serial_in(lnk.serial_in),
    .PROTECT_SCHEME_SELECT(pss), .BP_PROTECT(bp), .LOCK_BITS(lock_bits), .PROTECTED(prot),
    .WRITE_ENABLE_LATCH(write_enable_latch), .SUSPEND_FLAG(susp), .STATUS_VOL(stat_vol),
    .READ_PARAM_BYTE(rparam), .BYPASS_MODE_BYTE(bmode), .BUSY(busy), .ABORT(abort),
    .RESET_ARMED(armed));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge lnk.sclk) begin
    sh = {sh[6:0], lnk.serial_in};
    nb++;
  end
  always @(negedge lnk.cs_n) nb = 0;

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic done(input string s);
    $display("done: %s", s);
  endtask : done
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd_v = rdata;
    rs_v = rresp;
    rready <= 1'h0;
  endtask : rd
  task automatic cmd(input byte_t op, input logic [1:0] e);
    logic [1:0] r;
    wr(CMD_OFFSET, {24'h000000, op}, r);
    `CHK("bresp", e, r)
    if (e == RESP_OKAY) begin
      while (lnk.cs_n !== 1'h1) @(posedge clk);
      `CHK("bits", OPCODE_BITS, nb)
      `CHK("frame byte", op, sh)
      `CHK("idle sclk", 1'h0, lnk.sclk)
      repeat (10) @(posedge clk);
    end
  endtask : cmd
  // spare link frame, 6 ns serial clock
  task automatic frame(input logic [15:0] b, input int nbit);
    lnk2.cs_n = 1'h0;
    for (int i = 15; i > 15 - nbit; i--) begin
      lnk2.serial_in = b[i];
      #3 lnk2.sclk = 1'h1;
      #3 lnk2.sclk = 1'h0;
    end
    #3 lnk2.cs_n = 1'h1;
    lnk2.serial_in = ~lnk2.serial_in;
    repeat (12) @(posedge clk);
  endtask : frame

  initial begin
    #200000;
    $display("timeout");
    fails++;
    results();
  end

  initial begin
    {fails, num_checks, nb, sh} = '0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {vol_wr, par_wr, mod_wr, s_set, s_clr, vol_d, par_d, mod_d, bp} = '0;
    {lnk2.sclk, lnk2.cs_n, lnk2.serial_in} = 3'h2;
    wstrb = 4'hF;
    pss = 1'h1;
    rst = 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    `CHK("lock at reset", LOCK_ALL_SET, lock_bits)
    `CHK("prot reset", LOCK_ALL_SET, prot)
    cmd(OP_WRITE_ENABLE, RESP_SLVERR);
    rd(4'h8);
    `CHK("unmapped resp", RESP_SLVERR, rs_v)
    `CHK("unmapped data", 32'h00000000, rd_v)
    repeat (PU) @(posedge clk);
    rd(STATUS_OFFSET);
    `CHK("power-up done", 1'h1, rd_v[ST_PWR_OK])
    done("power-up");
    cmd(OP_GLOBAL_UNLOCK, RESP_OKAY);
    `CHK("unlock no latch", LOCK_ALL_SET, lock_bits)
    cmd(OP_WRITE_ENABLE, RESP_OKAY);
    `CHK("latch set", 1'h1, write_enable_latch)
    cmd(OP_GLOBAL_UNLOCK, RESP_OKAY);
    `CHK("global unlock", LOCK_ALL_CLEAR, lock_bits)
    `CHK("prot lock", LOCK_ALL_CLEAR, prot)
    bp <= 64'hF0F0000000A50000;
    pss <= 1'h0;
    repeat (3) @(posedge clk);
    `CHK("prot field", 64'hF0F0000000A50000, prot)
    pss <= 1'h1;
    cmd(OP_GLOBAL_LOCK, RESP_OKAY);
    `CHK("global lock", LOCK_ALL_SET, lock_bits)
    cmd(OP_GLOBAL_UNLOCK, RESP_OKAY);
    done("lock");
    {par_d, mod_d, vol_d} <= 24'h5AC33C;
    {par_wr, mod_wr, vol_wr, s_set} <= 4'hF;
    @(posedge clk);
    {par_wr, mod_wr, vol_wr, s_set} <= 4'h0;
    cmd(OP_RESET_ENABLE, RESP_OKAY);
    `CHK("armed", 1'h1, armed)
    rd(STATUS_OFFSET);
    `CHK("last opcode", OP_RESET_ENABLE, rd_v[ST_LAST_LO+:8])
    `CHK("link idle", 1'h0, rd_v[ST_BUSY])
    cmd(OP_WRITE_ENABLE, RESP_OKAY);
    `CHK("arm cancelled", 1'h0, armed)
    cmd(OP_RESET, RESP_OKAY);
    `CHK("no lone reset", LOCK_ALL_CLEAR, lock_bits)
    `CHK("param kept", 8'h5A, rparam)
    `CHK("suspend set", 1'h1, susp)
    cmd(OP_RESET_ENABLE, RESP_OKAY);
    cmd(OP_RESET, RESP_OKAY);
    `CHK("busy", 1'h1, busy)
    `CHK("lock restored", LOCK_ALL_SET, lock_bits)
    `CHK("latch cleared", 1'h0, write_enable_latch)
    `CHK("suspend cleared", 1'h0, susp)
    `CHK("param cleared", READ_PARAM_DEFAULT, rparam)
    `CHK("mode cleared", BYPASS_MODE_DEFAULT, bmode)
    `CHK("status cleared", STATUS_VOL_DEFAULT, stat_vol)
    par_wr <= 1'h1;
    @(posedge clk);
    par_wr <= 1'h0;
    cmd(OP_WRITE_ENABLE, RESP_SLVERR);
    `CHK("load busy", READ_PARAM_DEFAULT, rparam)
    while (busy !== 1'h0) @(posedge clk);
    do rd(STATUS_OFFSET); while (rd_v[ST_HOLDOFF] !== 1'h0);
    cmd(OP_WRITE_ENABLE, RESP_OKAY);
    `CHK("latch after reset", 1'h1, write_enable_latch)
    done("reset");
    frame(16'h0600, 8);
    frame(16'h9800, 9);
    `CHK("long frame", LOCK_ALL_SET, lock2)
    frame(16'h9800, 7);
    `CHK("short frame", LOCK_ALL_SET, lock2)
    frame(16'h6600, 8);
    frame(16'h0000, 7);
    `CHK("arm kept", 1'h1, armed2)
    frame(16'h9900, 9);
    `CHK("arm dropped", 1'h0, armed2)
    frame(16'h9800, 8);
    `CHK("spare unlock", LOCK_ALL_CLEAR, lock2)
    done("malformed frames");
    results();
  end
endmodule : global_lock_and_soft_reset_tb
